// [core/rrs_coord.sv]
// rrs_coord: reset timer, reclosing states and sequence-coordination shot counter
// assumes pins are asynchronous to REF_CLK and software reaches registers over APB
`timescale 1ns/100ps
`default_nettype none

module rrs_coord
#(
  parameter int unsigned STEP_CLKS = rrs_pkg::STEP_CLKS
)
(
  // clock and reset
  input  wire logic        REF_CLK,
  input  wire logic        RST_B,
  // apb slave
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [7:0]  PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // protection inputs
  input  wire logic        TRIP_IN,
  input  wire logic        BREAKER_CLOSED_INPUT,
  input  wire logic        BLOCK_RESET_TIMING_INPUT,
  input  wire logic        SEQ_COORD_INPUT,
  input  wire logic        RECLOSE_INIT_IN,
  // indications
  output logic             RESET_STATE_FLAG,
  output logic             CYCLE_STATE_FLAG,
  output logic             LOCKOUT_STATE_FLAG,
  output logic             RESET_TIMING_ACTIVE_FLAG,
  output logic             SHOT_ZERO_FLAG,
  output logic             SHOT_ONE_FLAG,
  output logic [2:0]       SHOT_COUNT,
  // interrupt
  output logic             IRQ
);

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [rrs_pkg::PIN_W-1:0]      sync1;
    logic [rrs_pkg::PIN_W-1:0]      sync2;
    logic                           ri_prev;
    logic [rrs_pkg::STEP_CNT_W-1:0] step_cnt;
    logic                           step;
    rrs_pkg::rrs_state_type         state;
    logic [2:0]                     shot;
    logic [2:0]                     last_shot;
    logic [rrs_pkg::DUR_W-1:0]      cyc_dur;
    logic [rrs_pkg::DUR_W-1:0]      lo_dur;
    logic [rrs_pkg::DUR_W-1:0]      timer;
    logic [rrs_pkg::INT_W-1:0]      int_stat;
    logic [rrs_pkg::INT_W-1:0]      int_mask;
    logic                           irq;
    logic                           pready;
    logic                           pslverr;
    logic [31:0]                    prdata;
    logic                           rs_flag;
    logic                           cy_flag;
    logic                           lo_flag;
    logic                           tmn_flag;
    logic                           shot0_flag;
    logic                           shot1_flag;
  } rrs_core_type;

  localparam logic [rrs_pkg::STEP_CNT_W-1:0] STEP_LAST =
    rrs_pkg::STEP_CNT_W'(STEP_CLKS - 1);

  rrs_core_type r_reg;
  rrs_core_type r_next;

  rrs_pick_if pk ();

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  function automatic logic [rrs_pkg::DUR_W-1:0] reset_load
  (
    input rrs_pkg::rrs_state_type    st,
    input logic [rrs_pkg::DUR_W-1:0] cyc,
    input logic [rrs_pkg::DUR_W-1:0] lo
  );
    logic [rrs_pkg::DUR_W-1:0] d;
    d = (st == rrs_pkg::ST_LOCKOUT) ? lo : cyc;
    if (d == '0)
      d = 16'h0001;
    return d;
  endfunction : reset_load

  function automatic logic [2:0] shot_inc
  (
    input logic [2:0] s
  );
    return (s >= rrs_pkg::SHOT_MAX) ? rrs_pkg::SHOT_MAX : s + 3'h1;
  endfunction : shot_inc

  function automatic logic addr_mapped
  (
    input logic [7:0] a
  );
    return (a == rrs_pkg::ADDR_CTRL)     || (a == rrs_pkg::ADDR_CYC_DUR)  ||
           (a == rrs_pkg::ADDR_LO_DUR)   || (a == rrs_pkg::ADDR_STATUS)   ||
           (a == rrs_pkg::ADDR_INT_STAT) || (a == rrs_pkg::ADDR_INT_MASK) ||
           (a == rrs_pkg::ADDR_TIMER);
  endfunction : addr_mapped

  // ---------------------------------------------------------------
  // pickup qualifier
  // ---------------------------------------------------------------
  assign pk.step  = r_reg.step;
  assign pk.level = r_reg.sync2[rrs_pkg::PIN_SEQ];

  rrs_pickup_qual u_qual
  (
    .clk   (REF_CLK),
    .rst_b (RST_B),
    .pk    (pk)
  );

  // ---------------------------------------------------------------
  // next state
  // ---------------------------------------------------------------
  always_comb
  begin
    logic                      trip;
    logic                      brkr;
    logic                      block;
    logic                      ri_rise;
    logic                      seq_inc;
    logic                      need;
    logic                      run;
    logic                      expire;
    logic                      enter_lo;
    logic                      acc;
    logic                      wr;
    logic [rrs_pkg::INT_W-1:0] ev;
    logic [rrs_pkg::INT_W-1:0] clr;
    logic [31:0]               rd;

    trip     = 1'h0;
    brkr     = 1'h0;
    block    = 1'h0;
    ri_rise  = 1'h0;
    seq_inc  = 1'h0;
    need     = 1'h0;
    run      = 1'h0;
    expire   = 1'h0;
    enter_lo = 1'h0;
    acc      = 1'h0;
    wr       = 1'h0;
    ev       = '0;
    clr      = '0;
    rd       = '0;
    r_next   = r_reg;

    // pin synchronisers
    r_next.sync1 = {RECLOSE_INIT_IN, SEQ_COORD_INPUT, BLOCK_RESET_TIMING_INPUT,
                    BREAKER_CLOSED_INPUT, TRIP_IN};
    r_next.sync2 = r_reg.sync1;
    trip         = r_reg.sync2[rrs_pkg::PIN_TRIP];
    brkr         = r_reg.sync2[rrs_pkg::PIN_BRKR];
    block        = r_reg.sync2[rrs_pkg::PIN_BLOCK];
    r_next.ri_prev = r_reg.sync2[rrs_pkg::PIN_RI];
    ri_rise      = r_reg.sync2[rrs_pkg::PIN_RI] && !r_reg.ri_prev;

    // processing step
    if (r_reg.step_cnt == STEP_LAST)
    begin
      r_next.step_cnt = '0;
      r_next.step     = 1'h1;
    end
    else
    begin
      r_next.step_cnt = r_reg.step_cnt + 1'h1;
      r_next.step     = 1'h0;
    end

    // sequence coordination
    seq_inc = pk.fire && !trip && brkr;

    // reset timer
    need = (r_reg.state != rrs_pkg::ST_RESET) || (r_reg.shot != 3'h0);
    run  = need && brkr && !trip && !block;
    if (seq_inc)
      r_next.timer = reset_load(rrs_pkg::ST_CYCLE, r_reg.cyc_dur, r_reg.lo_dur);
    else if (!run)
      r_next.timer = reset_load(r_reg.state, r_reg.cyc_dur, r_reg.lo_dur);
    else if (r_reg.step)
    begin
      if (r_reg.timer <= 16'h0001)
        expire = 1'h1;
      else
        r_next.timer = r_reg.timer - 1'h1;
    end

    // reclosing state and shot counter
    if (trip && (r_reg.shot >= r_reg.last_shot) && (r_reg.state != rrs_pkg::ST_LOCKOUT))
    begin
      r_next.state = rrs_pkg::ST_LOCKOUT;
      enter_lo     = 1'h1;
    end
    else if (expire)
    begin
      r_next.shot  = 3'h0;
      r_next.state = rrs_pkg::ST_RESET;
    end
    else if (seq_inc)
      r_next.shot = shot_inc(r_reg.shot);
    else if (ri_rise && (r_reg.state != rrs_pkg::ST_LOCKOUT) &&
             (r_reg.shot < r_reg.last_shot))
    begin
      r_next.shot  = shot_inc(r_reg.shot);
      r_next.state = rrs_pkg::ST_CYCLE;
    end

    if (r_next.state != r_reg.state)
      r_next.timer = reset_load(r_next.state, r_reg.cyc_dur, r_reg.lo_dur);

    // indications
    r_next.rs_flag  = (r_next.state == rrs_pkg::ST_RESET);
    r_next.cy_flag  = (r_next.state == rrs_pkg::ST_CYCLE);
    r_next.lo_flag  = (r_next.state == rrs_pkg::ST_LOCKOUT);
    r_next.tmn_flag = run && !expire && !seq_inc;
    r_next.shot0_flag = (r_next.shot == 3'h0);
    r_next.shot1_flag = (r_next.shot == 3'h1);

    // apb access
    acc = PSEL && PENABLE;
    wr  = acc && r_reg.pready && PWRITE && addr_mapped(PADDR);
    case (PADDR)
      rrs_pkg::ADDR_CTRL:
        rd[rrs_pkg::CTRL_LAST_LSB +: 3] = r_reg.last_shot;
      rrs_pkg::ADDR_CYC_DUR:
        rd[rrs_pkg::DUR_W-1:0] = r_reg.cyc_dur;
      rrs_pkg::ADDR_LO_DUR:
        rd[rrs_pkg::DUR_W-1:0] = r_reg.lo_dur;
      rrs_pkg::ADDR_STATUS:
      begin
        rd[rrs_pkg::STAT_RESET_BIT]     = r_reg.rs_flag;
        rd[rrs_pkg::STAT_CYC_BIT]       = r_reg.cy_flag;
        rd[rrs_pkg::STAT_LO_BIT]        = r_reg.lo_flag;
        rd[rrs_pkg::STAT_TMN_BIT]       = r_reg.tmn_flag;
        rd[rrs_pkg::STAT_SHOT_LSB +: 3] = r_reg.shot;
        rd[rrs_pkg::STAT_SHOT0_BIT]     = r_reg.shot0_flag;
        rd[rrs_pkg::STAT_SHOT1_BIT]     = r_reg.shot1_flag;
      end
      rrs_pkg::ADDR_INT_STAT:
        rd[rrs_pkg::INT_W-1:0] = r_reg.int_stat;
      rrs_pkg::ADDR_INT_MASK:
        rd[rrs_pkg::INT_W-1:0] = r_reg.int_mask;
      rrs_pkg::ADDR_TIMER:
        rd[rrs_pkg::DUR_W-1:0] = r_reg.timer;
      default:
        rd = '0;
    endcase

    if (acc && !r_reg.pready)
    begin
      r_next.pready  = 1'h1;
      r_next.pslverr = !addr_mapped(PADDR);
      r_next.prdata  = PWRITE ? 32'h0000_0000 : rd;
    end
    else
    begin
      r_next.pready  = 1'h0;
      r_next.pslverr = 1'h0;
    end

    if (wr)
    begin
      case (PADDR)
        rrs_pkg::ADDR_CTRL:
          r_next.last_shot = PWDATA[rrs_pkg::CTRL_LAST_LSB +: 3];
        rrs_pkg::ADDR_CYC_DUR:
          r_next.cyc_dur = PWDATA[rrs_pkg::DUR_W-1:0];
        rrs_pkg::ADDR_LO_DUR:
          r_next.lo_dur = PWDATA[rrs_pkg::DUR_W-1:0];
        rrs_pkg::ADDR_INT_STAT:
          clr = PWDATA[rrs_pkg::INT_W-1:0];
        rrs_pkg::ADDR_INT_MASK:
          r_next.int_mask = PWDATA[rrs_pkg::INT_W-1:0];
        default:
          clr = '0;
      endcase
    end

    // interrupts: a new event wins over a clear in the same cycle
    ev[rrs_pkg::INT_SEQ_BIT] = seq_inc;
    ev[rrs_pkg::INT_LO_BIT]  = enter_lo;
    ev[rrs_pkg::INT_EXP_BIT] = expire;
    for (int i = 0; i < rrs_pkg::INT_W; i++)
      r_next.int_stat[i] = ev[i] || (r_reg.int_stat[i] && !clr[i]);
    r_next.irq = |(r_next.int_stat & r_next.int_mask);
  end

  // ---------------------------------------------------------------
  // registers
  // ---------------------------------------------------------------
  always_ff @(posedge REF_CLK or negedge RST_B)
  begin
    if (!RST_B)
    begin
      r_reg           <= '0;
      r_reg.state     <= rrs_pkg::ST_RESET;
      r_reg.last_shot <= rrs_pkg::LAST_SHOT_RST;
      r_reg.cyc_dur   <= rrs_pkg::CYC_DUR_RST;
      r_reg.lo_dur    <= rrs_pkg::LO_DUR_RST;
      r_reg.timer     <= rrs_pkg::CYC_DUR_RST;
      r_reg.int_mask  <= rrs_pkg::INT_MASK_RST;
      r_reg.rs_flag    <= 1'h1;
      r_reg.shot0_flag <= 1'h1;
    end
    else
      r_reg <= r_next;
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign PRDATA                   = r_reg.prdata;
  assign PREADY                   = r_reg.pready;
  assign PSLVERR                  = r_reg.pslverr;
  assign RESET_STATE_FLAG         = r_reg.rs_flag;
  assign CYCLE_STATE_FLAG         = r_reg.cy_flag;
  assign LOCKOUT_STATE_FLAG       = r_reg.lo_flag;
  assign RESET_TIMING_ACTIVE_FLAG = r_reg.tmn_flag;
  assign SHOT_ZERO_FLAG           = r_reg.shot0_flag;
  assign SHOT_ONE_FLAG            = r_reg.shot1_flag;
  assign SHOT_COUNT               = r_reg.shot;
  assign IRQ                      = r_reg.irq;

endmodule : rrs_coord

`default_nettype wire

// [core/rrs_pkg.sv]
// rrs_pkg: constants and types of the reclose reset-timer and shot-counter block
// assumes a 40 MHz reference clock and a 60 Hz power system, processed in quarter cycles
package rrs_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int unsigned CLK_HZ              = 40_000_000;
  localparam int unsigned LINE_HZ             = 60;
  localparam int unsigned STEPS_PER_CYCLE     = 4;
  localparam int unsigned STEP_CLKS           = CLK_HZ / (LINE_HZ * STEPS_PER_CYCLE);
  localparam int unsigned PICKUP_MIN_CENTICYC = 125;
  localparam int unsigned PICKUP_MIN_STEPS    =
    (PICKUP_MIN_CENTICYC * STEPS_PER_CYCLE + 99) / 100;
  localparam int unsigned PICKUP_CNT_W        = 3;
  localparam int unsigned STEP_CNT_W          = 18;
  localparam int unsigned DUR_W               = 16;

  // ---------------------------------------------------------------
  // shot counter
  // ---------------------------------------------------------------
  localparam logic [2:0] SHOT_MAX      = 3'h4;
  localparam logic [2:0] LAST_SHOT_RST = 3'h2;

  // ---------------------------------------------------------------
  // register offsets and reset values
  // ---------------------------------------------------------------
  localparam logic [7:0]  ADDR_CTRL     = 8'h00;
  localparam logic [7:0]  ADDR_CYC_DUR  = 8'h04;
  localparam logic [7:0]  ADDR_LO_DUR   = 8'h08;
  localparam logic [7:0]  ADDR_STATUS   = 8'h0c;
  localparam logic [7:0]  ADDR_INT_STAT = 8'h10;
  localparam logic [7:0]  ADDR_INT_MASK = 8'h14;
  localparam logic [7:0]  ADDR_TIMER    = 8'h18;
  localparam logic [15:0] CYC_DUR_RST   = 16'h0960;
  localparam logic [15:0] LO_DUR_RST    = 16'h0960;
  localparam logic [2:0]  INT_MASK_RST  = 3'h0;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int unsigned CTRL_LAST_LSB  = 0;
  localparam int unsigned STAT_RESET_BIT = 0;
  localparam int unsigned STAT_CYC_BIT   = 1;
  localparam int unsigned STAT_LO_BIT    = 2;
  localparam int unsigned STAT_TMN_BIT   = 3;
  localparam int unsigned STAT_SHOT_LSB  = 4;
  localparam int unsigned STAT_SHOT0_BIT = 7;
  localparam int unsigned STAT_SHOT1_BIT = 8;
  localparam int unsigned INT_SEQ_BIT    = 0;
  localparam int unsigned INT_LO_BIT     = 1;
  localparam int unsigned INT_EXP_BIT    = 2;
  localparam int unsigned INT_W          = 3;

  // ---------------------------------------------------------------
  // synchronised pin indices
  // ---------------------------------------------------------------
  localparam int unsigned PIN_TRIP  = 0;
  localparam int unsigned PIN_BRKR  = 1;
  localparam int unsigned PIN_BLOCK = 2;
  localparam int unsigned PIN_SEQ   = 3;
  localparam int unsigned PIN_RI    = 4;
  localparam int unsigned PIN_W     = 5;

  // ---------------------------------------------------------------
  // reclosing states
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RESET,
    ST_CYCLE,
    ST_LOCKOUT
  } rrs_state_type;

endpackage : rrs_pkg

// [core/rrs_pick_if.sv]
// rrs_pick_if: processing step, pickup level and qualified pickup event
// assumes both ends run on the same reference clock
`timescale 1ns/100ps
`default_nettype none

interface rrs_pick_if;
  logic step;
  logic level;
  logic fire;

  modport main (output step, output level, input fire);
  modport qual (input step, input level, output fire);
endinterface : rrs_pick_if

`default_nettype wire

// [core/rrs_pickup_qual.sv]
// rrs_pickup_qual: measures a pickup in processing steps and reports its dropout if it lasted PICKUP_MIN_STEPS steps
// assumes level is already synchronised and step is a one-clock pulse
`timescale 1ns/100ps
`default_nettype none

module rrs_pickup_qual
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_b,
  // pickup link
  rrs_pick_if.qual  pk
);

  typedef struct packed {
    logic [rrs_pkg::PICKUP_CNT_W-1:0] cnt;
    logic                             fire;
  } rrs_qual_type;

  localparam logic [rrs_pkg::PICKUP_CNT_W-1:0] CNT_MIN =
    rrs_pkg::PICKUP_CNT_W'(rrs_pkg::PICKUP_MIN_STEPS);

  rrs_qual_type q_reg;
  rrs_qual_type q_next;

  // ---------------------------------------------------------------
  // pickup timing
  // ---------------------------------------------------------------
  always_comb
  begin
    q_next      = q_reg;
    q_next.fire = 1'h0;
    if (pk.step)
    begin
      if (pk.level)
      begin
        if (q_reg.cnt < CNT_MIN)
          q_next.cnt = q_reg.cnt + 1'h1;
      end
      else
      begin
        q_next.fire = (q_reg.cnt >= CNT_MIN);
        q_next.cnt  = '0;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      q_reg <= '0;
    else
      q_reg <= q_next;
  end

  assign pk.fire = q_reg.fire;

endmodule : rrs_pickup_qual

`default_nettype wire

// [dv/rrs_coord_chk.sv]
// rrs_coord_chk: port assertions for rrs_coord
// assumes it is bound into rrs_coord and sees its ports only
`timescale 1ns/100ps
`default_nettype none

module rrs_coord_chk
#(
  parameter int unsigned STEP_CLKS = rrs_pkg::STEP_CLKS
)
(
  // clock and reset
  input wire logic       REF_CLK,
  input wire logic       RST_B,
  // apb
  input wire logic       PSEL,
  input wire logic       PENABLE,
  input wire logic       PREADY,
  // pins
  input wire logic       BREAKER_CLOSED_INPUT,
  input wire logic       BLOCK_RESET_TIMING_INPUT,
  input wire logic       RECLOSE_INIT_IN,
  // indications
  input wire logic       RESET_STATE_FLAG,
  input wire logic       CYCLE_STATE_FLAG,
  input wire logic       LOCKOUT_STATE_FLAG,
  input wire logic       RESET_TIMING_ACTIVE_FLAG,
  input wire logic       SHOT_ZERO_FLAG,
  input wire logic       SHOT_ONE_FLAG,
  input wire logic [2:0] SHOT_COUNT
);
  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (!RST_B);

  chk_state_onehot: assert property (
    $onehot({RESET_STATE_FLAG, CYCLE_STATE_FLAG, LOCKOUT_STATE_FLAG}))
    else $error("state flags not one-hot");
  chk_shot_cap: assert property (SHOT_COUNT <= 3'h4)
    else $error("shot count above four");
  chk_shot_zero_decode: assert property (SHOT_ZERO_FLAG == (SHOT_COUNT == 3'h0))
    else $error("shot zero flag wrong");
  chk_shot_one_decode: assert property (SHOT_ONE_FLAG == (SHOT_COUNT == 3'h1))
    else $error("shot one flag wrong");
  chk_block_halts: assert property (
    BLOCK_RESET_TIMING_INPUT [*6] |-> !RESET_TIMING_ACTIVE_FLAG)
    else $error("reset timing while blocked");
  chk_shot_step_one: assert property (
    (SHOT_COUNT > $past(SHOT_COUNT)) |-> (SHOT_COUNT == $past(SHOT_COUNT) + 3'h1))
    else $error("shot count jumped");
  chk_drop_to_zero: assert property (
    (SHOT_COUNT < $past(SHOT_COUNT)) |-> (SHOT_COUNT == 3'h0))
    else $error("shot count fell but not to zero");
  chk_breaker_gate: assert property (
    (!BREAKER_CLOSED_INPUT && !RECLOSE_INIT_IN) [*6] |=> (SHOT_COUNT <= $past(SHOT_COUNT)))
    else $error("shot added with breaker open");
  chk_lockout_exit: assert property (
    $fell(LOCKOUT_STATE_FLAG) |-> (RESET_STATE_FLAG && SHOT_COUNT == 3'h0))
    else $error("lockout left wrongly");
  chk_idle_quiet: assert property (
    (RESET_STATE_FLAG && SHOT_ZERO_FLAG) [*2] |-> !RESET_TIMING_ACTIVE_FLAG)
    else $error("timing flag while idle");
  chk_apb_answer: assert property ((PSEL && PENABLE && !PREADY) |=> PREADY)
    else $error("apb answer late");
endmodule : rrs_coord_chk

bind rrs_coord rrs_coord_chk #(.STEP_CLKS(STEP_CLKS)) i_chk (
  .REF_CLK(REF_CLK), .RST_B(RST_B), .PSEL(PSEL), .PENABLE(PENABLE), .PREADY(PREADY),
  .BREAKER_CLOSED_INPUT(BREAKER_CLOSED_INPUT), .RECLOSE_INIT_IN(RECLOSE_INIT_IN),
  .BLOCK_RESET_TIMING_INPUT(BLOCK_RESET_TIMING_INPUT), .SHOT_COUNT(SHOT_COUNT),
  .RESET_STATE_FLAG(RESET_STATE_FLAG), .CYCLE_STATE_FLAG(CYCLE_STATE_FLAG),
  .LOCKOUT_STATE_FLAG(LOCKOUT_STATE_FLAG), .SHOT_ZERO_FLAG(SHOT_ZERO_FLAG),
  .RESET_TIMING_ACTIVE_FLAG(RESET_TIMING_ACTIVE_FLAG), .SHOT_ONE_FLAG(SHOT_ONE_FLAG));

`default_nettype wire

// [dv/rrs_recloser_model.sv]
// rrs_recloser_model: breaker status and downstream recloser pickup
// assumes its tasks are called from the bench on rising edges
`timescale 1ns/100ps
`default_nettype none

module rrs_recloser_model
(
  // clock
  input  wire logic clk,
  // pins toward the block
  output var logic  brk_closed,
  output var logic  seq_pickup
);
  initial brk_closed = 1'h1;
  initial seq_pickup = 1'h0;

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic set_breaker(input logic v);
    @(posedge clk);
    brk_closed <= v;
  endtask : set_breaker

  // one fault cleared downstream: pickup, then dropout
  task automatic operate(input int hi, input int lo);
    @(posedge clk);
    seq_pickup <= 1'h1;
    repeat (hi) @(posedge clk);
    seq_pickup <= 1'h0;
    repeat (lo) @(posedge clk);
  endtask : operate
endmodule : rrs_recloser_model

`default_nettype wire

// [dv/testbench.sv]
// testbench: drives rrs_coord over apb and its pins
// assumes a short processing step for simulation
`timescale 1ns/100ps
`default_nettype none

module testbench;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  localparam int STEP = 4;
  typedef struct {logic [7:0] a; logic [31:0] wd; logic [31:0] rd; logic e;} rrs_row_type;
  rrs_row_type rows [7] = '{
    '{8'h04, 32'h10, 32'h10, 1'h0},
    '{8'h08, 32'h14, 32'h14, 1'h0},
    '{8'h00, 32'hfa, 32'h02, 1'h0},
    '{8'h14, 32'h04, 32'h04, 1'h0},
    '{8'h0c, 32'hff, 32'h81, 1'h0},
    '{8'h18, 32'h05, 32'h10, 1'h0},
    '{8'h1c, 32'h01, 32'h00, 1'h1}};
  logic [7:0]  ra [4] = '{8'h00, 8'h04, 8'h08, 8'h14};
  logic [31:0] rv [4] = '{32'h2, 32'h960, 32'h960, 32'h0};
  logic        ref_clk = 1'h0;
  logic        rst_b   = 1'h0;
  logic        psel    = 1'h0;
  logic        penable = 1'h0;
  logic        pwrite  = 1'h0;
  logic [7:0]  paddr   = 8'h00;
  logic [31:0] pwdata  = 32'h0;
  logic        trip    = 1'h0;
  logic        blk     = 1'h0;
  logic        ri      = 1'h0;
  logic [31:0] prdata;
  logic        pready, pslverr, brk, seq, irq;
  logic        f_rst, f_cyc, f_lo, f_tmn, f_shot0, f_shot1;
  logic [2:0]  shot;
  int          n_mismatch = 0;
  int          comparisons = 0;
  int          cycles = 0;

  always #12.5 ref_clk = ~ref_clk;

  rrs_coord #(.STEP_CLKS(STEP)) i_dut (
    .REF_CLK(ref_clk), .RST_B(rst_b), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .TRIP_IN(trip), .BREAKER_CLOSED_INPUT(brk), .BLOCK_RESET_TIMING_INPUT(blk),
    .SEQ_COORD_INPUT(seq), .RECLOSE_INIT_IN(ri), .RESET_STATE_FLAG(f_rst),
    .CYCLE_STATE_FLAG(f_cyc), .LOCKOUT_STATE_FLAG(f_lo), .RESET_TIMING_ACTIVE_FLAG(f_tmn),
    .SHOT_ZERO_FLAG(f_shot0), .SHOT_ONE_FLAG(f_shot1), .SHOT_COUNT(shot), .IRQ(irq));

  rrs_recloser_model i_rec (.clk(ref_clk), .brk_closed(brk), .seq_pickup(seq));

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : close_out

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic err);
    int k;
    @(posedge ref_clk);
    psel    <= 1'h1;
    penable <= 1'h0;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge ref_clk);
    penable <= 1'h1;
    k = 0;
    do
    begin
      @(posedge ref_clk);
      k++;
    end
    while (pready !== 1'h1 && k < 40);
    rd = prdata;
    err = pslverr;
    psel    <= 1'h0;
    penable <= 1'h0;
    check({31'h0, k < 40}, 32'h1);
  endtask : apb

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] x, input logic xe);
    logic [31:0] r;
    logic        e;
    apb(1'h0, a, 32'h0, r, e);
    check(r, x);
    check({31'h0, e}, {31'h0, xe});
  endtask : rd_chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'h1, a, d, r, e);
  endtask : wr

  task automatic wait_idle(input int lim);
    int k;
    k = 0;
    while (!(f_rst === 1'h1 && shot === 3'h0) && k < lim)
    begin
      @(posedge ref_clk);
      k++;
    end
    check({31'h0, k < lim}, 32'h1);
  endtask : wait_idle

  task automatic op();
    i_rec.operate(6 * STEP, 3 * STEP);
  endtask : op

  // ---------------------------------------------------------------
  // sequence
  // ---------------------------------------------------------------
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      check(32'h0, 32'h1);
      close_out();
    end
  end

  initial
  begin
    repeat (12) @(posedge ref_clk);
    rst_b <= 1'h1;
    @(posedge ref_clk);
    check(f_rst, 32'h1);
    check(f_shot0, 32'h1);
    check({f_cyc, f_lo, f_tmn, f_shot1, irq, shot}, 32'h0);
    for (int i = 0; i < 4; i++) rd_chk(ra[i], rv[i], 1'h0);
    for (int i = 0; i < 7; i++)
    begin
      wr(rows[i].a, rows[i].wd);
      rd_chk(rows[i].a, rows[i].rd, rows[i].e);
    end
    for (int i = 1; i <= 5; i++)
    begin
      op();
      check(shot, (i > 4) ? 32'h4 : i);
      check(f_rst, 32'h1);
      check(f_shot1, {31'h0, i == 1});
      check(f_tmn, 32'h1);
    end
    blk <= 1'h1;
    repeat (30 * STEP) @(posedge ref_clk);
    check(shot, 32'h4);
    check(f_tmn, 32'h0);
    blk <= 1'h0;
    repeat (10 * STEP) @(posedge ref_clk);
    blk <= 1'h1;
    repeat (2 * STEP) @(posedge ref_clk);
    blk <= 1'h0;
    repeat (11 * STEP) @(posedge ref_clk);
    check(shot, 32'h4);
    wait_idle(20 * STEP);
    @(posedge ref_clk);
    check(irq, 32'h1);
    rd_chk(8'h10, 32'h5, 1'h0);
    wr(8'h10, 32'h7);
    rd_chk(8'h10, 32'h0, 1'h0);
    check(irq, 32'h0);
    trip <= 1'h1;
    op();
    trip <= 1'h0;
    check(shot, 32'h0);
    i_rec.set_breaker(1'h0);
    op();
    i_rec.set_breaker(1'h1);
    check(shot, 32'h0);
    repeat (2) op();
    trip <= 1'h1;
    repeat (8) @(posedge ref_clk);
    check(f_lo, 32'h1);
    check(f_cyc, 32'h0);
    trip <= 1'h0;
    repeat (19 * STEP) @(posedge ref_clk);
    check(f_lo, 32'h1);
    wait_idle(8 * STEP);
    ri <= 1'h1;
    repeat (6) @(posedge ref_clk);
    ri <= 1'h0;
    check(f_cyc, 32'h1);
    wait_idle(24 * STEP);
    close_out();
  end
endmodule : testbench

`default_nettype wire
